/* File: hdl/recorder_defines.svh */
/*
 Constants of the feeder relay recorder: depths, limits, indices.
 Assumes inclusion by the recorder package and design file.
*/
`ifndef RECORDER_DEFINES_SVH
`define RECORDER_DEFINES_SVH

// Energy accumulator limit and width
`define ENERGY_W     24
`define ENERGY_MAX   24'h98967f

// Record depths
`define TRIP_DEPTH   10
`define EVT_DEPTH    100
`define N_MEAS       8

// Event sources: digital I/O, then starts, then trips
`define N_DIO        8
`define N_PROT       16
`define N_SRC        40
`define FID_START    8
`define FID_TRIP     24

// Operation counters and breaker indices
`define CNT_W        16
`define N_CNT        29
`define IDX_AUTOMATIC_BREAKER_OPENINGS   25
`define IDX_AUTOMATIC_BREAKER_CLOSINGS   26
`define IDX_MANUAL_BREAKER_OPENINGS   27
`define IDX_MANUAL_BREAKER_CLOSINGS   28
`define IDX_TOT_OP   29
`define IDX_TOT_CL   30

`endif

/* File: hdl/recorder_pkg.sv */
/*
 Types of the feeder relay recorder.
 Assumes the defines header sits on the include path.
*/
`default_nettype none
package recorder_pkg;
`include "recorder_defines.svh"

    // Real-time clock stamp, millisecond resolution
    typedef struct packed {
        logic [6:0] year;
        logic [3:0] month;
        logic [4:0] day;
        logic [4:0] hour;
        logic [5:0] minute;
        logic [5:0] second;
        logic [9:0] msec;
    } stamp_t;

    typedef logic [15:0]            meas_t;
    typedef logic [5:0]             fid_t;
    typedef logic [`ENERGY_W-1:0]   energy_t;
    typedef logic [`CNT_W-1:0]      count_t;

    typedef struct packed {
        fid_t   fid;
        logic   rise;
        stamp_t ts;
    } event_t;

    typedef struct packed {
        fid_t                   fid;
        stamp_t                 ts;
        meas_t [`N_MEAS-1:0]    meas;
    } trip_t;

    // Whole state of the recorder
    typedef struct packed {
        logic [`N_DIO-1:0]          dio1;
        logic [`N_DIO-1:0]          dio2;
        logic [`N_SRC-1:0]          logged;
        energy_t [3:0]              en;
        count_t [`N_CNT-1:0]        cnt;
        trip_t [`TRIP_DEPTH-1:0]    trip;
        logic [3:0]                 twp;
        logic [3:0]                 tcnt;
        logic [3:0]                 tcur;
        logic [2:0]                 vcur;
        event_t [`EVT_DEPTH-1:0]    evt;
        logic [6:0]                 ewp;
        logic [6:0]                 ecnt;
        logic [6:0]                 ecur;
        logic                       done;
        trip_t                      tout;
        event_t                     eout;
        logic [16:0]                cval;
    } rec_state_t;

endpackage
`default_nettype wire

/* File: hdl/relay_event_trip_recorder.sv */
/*
 Recording block of a feeder protection relay: energy accumulators,
 trip record, operation counters and event log, with browse cursors.
 Assumes stamps, levels, ticks and commands come from logic on i_clk;
 only the digital I/O levels arrive from pins and are synchronised.
*/
// Function
// - Four energy accumulators wrap past 9999999.
// - Energy erase clears all four together.
// - Completed erase pulses command done.
// - Ten newest trips with function, measurements.
// - New trip overwrites oldest when full.
// - Trip erase discards every trip entry.
// - Empty trip record reports no trips.
// - Trip entry stamped year to milliseconds.
// - Trip measurements readable one after another.
// - Per-function operation counters from zero.
// - Program may reset or preload counters.
// - Breaker totals equal manual plus automatic.
// - Log I/O changes, starts, trips, resets.
// - Event log keeps hundred newest entries.
// - Event holds function, edge, millisecond stamp.
// - Event erase removes all entries.
// - Empty event log reports no events.
// - Browse entries chronologically with increase, decrease.
// - Start, trip rise; trip reset falls.
`timescale 1ns/1ps
`default_nettype none
`include "recorder_defines.svh"

module relay_event_trip_recorder (
    input  wire logic                       i_clk,
    input  wire logic                       i_rst_b,
    input  wire recorder_pkg::stamp_t       i_stamp,
    input  wire logic [3:0]                 i_energy_tick,
    input  wire logic                       i_energy_erase,
    input  wire logic                       i_trip_erase,
    input  wire logic                       i_event_erase,
    output logic                            o_cmd_done,
    output recorder_pkg::energy_t [3:0]     o_energy,
    input  wire logic [`N_DIO-1:0]          i_dio,
    input  wire logic [`N_PROT-1:0]         i_start,
    input  wire logic [`N_PROT-1:0]         i_trip,
    input  wire recorder_pkg::meas_t [`N_MEAS-1:0] i_meas,
    input  wire logic                       i_trip_next,
    input  wire logic                       i_trip_prev,
    input  wire logic                       i_val_next,
    input  wire logic                       i_val_prev,
    output logic                            o_no_trips,
    output logic [3:0]                      o_trip_count,
    output recorder_pkg::fid_t              o_trip_fid,
    output recorder_pkg::stamp_t            o_trip_stamp,
    output recorder_pkg::meas_t             o_trip_value,
    output logic [2:0]                      o_trip_value_idx,
    input  wire logic                       i_event_next,
    input  wire logic                       i_event_prev,
    output logic                            o_no_events,
    output logic [6:0]                      o_event_count,
    output recorder_pkg::fid_t              o_event_fid,
    output logic                            o_event_rise,
    output recorder_pkg::stamp_t            o_event_stamp,
    input  wire logic [`N_CNT-1:0]          i_op_tick,
    input  wire logic                       i_cnt_load,
    input  wire logic [4:0]                 i_cnt_sel,
    input  wire recorder_pkg::count_t       i_cnt_value,
    input  wire logic [4:0]                 i_cnt_view,
    output logic [16:0]                     o_cnt_value
);
    import recorder_pkg::*;

    rec_state_t         q;
    rec_state_t         d;
    logic [`N_SRC-1:0]  src;
    logic [`N_SRC-1:0]  diff;
    logic               found;
    logic [5:0]         pick;
    logic               rise;
    logic               ev_log;
    logic               tr_log;

    // Chronological index to physical slot of a circular buffer
    function automatic logic [6:0] slot(input logic [6:0] wp, input logic [6:0] cnt,
                                        input logic [6:0] idx, input logic [8:0] depth);
        logic [8:0] t;
        t = {2'h0, wp} + depth - {2'h0, cnt} + {2'h0, idx};
        if (t >= depth) begin
            t = t - depth;
        end
        if (t >= depth) begin
            t = t - depth;
        end
        return t[6:0];
    endfunction

    // Lowest source whose level differs from its last logged level
    always_comb begin
        src   = {i_trip, i_start, q.dio2};
        diff  = src ^ q.logged;
        found = 1'b0;
        pick  = 6'h00;
        for (int k = `N_SRC - 1; k >= 0; k--) begin
            if (diff[k]) begin
                found = 1'b1;
                pick  = 6'(k);
            end
        end
        rise   = src[pick];
        // A start that drops leaves no entry; trip drop is a reset
        ev_log = found && (rise || pick < 6'(`FID_START) || pick >= 6'(`FID_TRIP));
        tr_log = found && rise && pick >= 6'(`FID_TRIP);
    end

    // Next state of the whole recorder
    always_comb begin
        d      = q;
        d.dio1 = i_dio;
        d.dio2 = q.dio1;
        d.done = i_energy_erase || i_trip_erase || i_event_erase;

        // Energy accumulators: erase first, else count and wrap
        for (int k = 0; k < 4; k++) begin
            if (i_energy_erase) begin
                d.en[k] = '0;
            end else if (i_energy_tick[k]) begin
                d.en[k] = (q.en[k] == `ENERGY_MAX) ? '0 : q.en[k] + 24'h1;
            end
        end

        // Operation counters: a preload beats a tick
        for (int k = 0; k < `N_CNT; k++) begin
            if (i_cnt_load && i_cnt_sel == 5'(k)) begin
                d.cnt[k] = i_cnt_value;
            end else if (i_op_tick[k]) begin
                d.cnt[k] = q.cnt[k] + 16'h1;
            end
        end

        // Event source levels are marked as seen once picked
        if (found) begin
            d.logged[pick] = rise;
        end

        // Event log: erase, then append the new entry
        if (i_event_erase) begin
            d.ewp  = '0;
            d.ecnt = '0;
            d.ecur = '0;
        end
        if (ev_log) begin
            d.evt[d.ewp] = '{fid: pick, rise: rise, ts: i_stamp};
            d.ewp = (d.ewp == 7'(`EVT_DEPTH - 1)) ? 7'h00 : d.ewp + 7'h1;
            if (d.ecnt != 7'(`EVT_DEPTH)) begin
                d.ecnt = d.ecnt + 7'h1;
            end
        end
        if (i_event_next && {1'b0, d.ecur} + 8'h1 < {1'b0, d.ecnt}) begin
            d.ecur = d.ecur + 7'h1;
        end else if (i_event_prev && d.ecur != 7'h00) begin
            d.ecur = d.ecur - 7'h1;
        end

        // Trip record: erase, then append oldest-out
        if (i_trip_erase) begin
            d.twp  = '0;
            d.tcnt = '0;
            d.tcur = '0;
            d.vcur = '0;
        end
        if (tr_log) begin
            d.trip[d.twp] = '{fid: pick, ts: i_stamp, meas: i_meas};
            d.twp = (d.twp == 4'(`TRIP_DEPTH - 1)) ? 4'h0 : d.twp + 4'h1;
            if (d.tcnt != 4'(`TRIP_DEPTH)) begin
                d.tcnt = d.tcnt + 4'h1;
            end
        end
        if (i_trip_next && d.tcur + 4'h1 < d.tcnt) begin
            d.tcur = d.tcur + 4'h1;
            d.vcur = '0;
        end else if (i_trip_prev && d.tcur != 4'h0) begin
            d.tcur = d.tcur - 4'h1;
            d.vcur = '0;
        end
        if (i_val_next) begin
            d.vcur = d.vcur + 3'h1;
        end else if (i_val_prev) begin
            d.vcur = d.vcur - 3'h1;
        end

        // Entries under the cursors, oldest at cursor zero
        d.eout = d.evt[slot(d.ewp, d.ecnt, d.ecur, 9'(`EVT_DEPTH))];
        d.tout = d.trip[4'(slot({3'h0, d.twp}, {3'h0, d.tcnt}, {3'h0, d.tcur},
                               9'(`TRIP_DEPTH)))];

        // Counter view, with breaker totals summed
        if (i_cnt_view == 5'(`IDX_TOT_OP)) begin
            d.cval = {1'b0, d.cnt[`IDX_MANUAL_BREAKER_OPENINGS]} + {1'b0, d.cnt[`IDX_AUTOMATIC_BREAKER_OPENINGS]};
        end else if (i_cnt_view == 5'(`IDX_TOT_CL)) begin
            d.cval = {1'b0, d.cnt[`IDX_MANUAL_BREAKER_CLOSINGS]} + {1'b0, d.cnt[`IDX_AUTOMATIC_BREAKER_CLOSINGS]};
        end else if (i_cnt_view < 5'(`N_CNT)) begin
            d.cval = {1'b0, d.cnt[i_cnt_view]};
        end else begin
            d.cval = 17'h00000; // Unused view code reads zero
        end
    end

    // State register
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign o_cmd_done       = q.done;
    assign o_energy         = q.en;
    assign o_no_trips       = (q.tcnt == 4'h0);
    assign o_trip_count     = q.tcnt;
    assign o_trip_fid       = q.tout.fid;
    assign o_trip_stamp     = q.tout.ts;
    assign o_trip_value     = q.tout.meas[q.vcur];
    assign o_trip_value_idx = q.vcur;
    assign o_no_events      = (q.ecnt == 7'h00);
    assign o_event_count    = q.ecnt;
    assign o_event_fid      = q.eout.fid;
    assign o_event_rise     = q.eout.rise;
    assign o_event_stamp    = q.eout.ts;
    assign o_cnt_value      = q.cval;

    // Checks on the recorder behaviour
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    a_energy_wrap: assert property (
        (q.en[0] == `ENERGY_MAX && i_energy_tick[0] && !i_energy_erase) |=> o_energy[0] == '0)
        else $error("energy did not wrap to zero");
    a_energy_erase: assert property (
        i_energy_erase |=> o_energy == '0)
        else $error("energy erase left a nonzero accumulator");
    a_cmd_done: assert property (
        (i_trip_erase || i_event_erase || i_energy_erase) |=> o_cmd_done)
        else $error("command done not raised after erase");
    a_done_pulse: assert property (
        !(i_trip_erase || i_event_erase || i_energy_erase) |=> !o_cmd_done)
        else $error("command done raised without an erase");
    a_trip_depth: assert property (
        q.tcnt <= 4'(`TRIP_DEPTH))
        else $error("trip count beyond depth");
    a_trip_full: assert property (
        (tr_log && !i_trip_erase && q.tcnt == 4'(`TRIP_DEPTH))
            |=> q.tcnt == 4'(`TRIP_DEPTH) && q.twp != $past(q.twp))
        else $error("full trip record did not overwrite oldest");
    a_trip_erase: assert property (
        (i_trip_erase && !tr_log) |=> o_no_trips && o_trip_count == 4'h0)
        else $error("trip erase left entries");
    a_trip_stamp: assert property (
        (tr_log && !i_trip_erase) |=> q.trip[$past(q.twp)].ts == $past(i_stamp))
        else $error("trip stamp not latched at detection");
    a_cnt_tick: assert property (
        (i_op_tick[3] && !(i_cnt_load && i_cnt_sel == 5'h03))
            |=> q.cnt[3] == $past(q.cnt[3]) + 16'h1)
        else $error("operation counter missed a tick");
    a_cnt_load: assert property (
        (i_cnt_load && i_cnt_sel < 5'(`N_CNT))
            |=> q.cnt[$past(i_cnt_sel)] == $past(i_cnt_value))
        else $error("counter preload not taken");
    a_total_op: assert property (
        i_cnt_view == 5'(`IDX_TOT_OP)
            |=> o_cnt_value == {1'b0, q.cnt[`IDX_MANUAL_BREAKER_OPENINGS]} + {1'b0, q.cnt[`IDX_AUTOMATIC_BREAKER_OPENINGS]})
        else $error("opening total differs from sum");
    a_evt_depth: assert property (
        q.ecnt <= 7'(`EVT_DEPTH))
        else $error("event count beyond depth");
    a_evt_entry: assert property (
        (ev_log && !i_event_erase) |=> q.evt[$past(q.ewp)].fid == $past(pick)
            && q.evt[$past(q.ewp)].rise == $past(rise))
        else $error("event entry wrong function or edge");
    a_evt_erase: assert property (
        (i_event_erase && !ev_log) |=> o_no_events)
        else $error("event erase left entries");
    a_evt_browse: assert property (
        (i_event_next && !i_event_erase && {1'b0, q.ecur} + 8'h1 < {1'b0, q.ecnt})
            |=> q.ecur == $past(q.ecur) + 7'h1)
        else $error("event cursor did not step forward");
    a_evt_back: assert property (
        (i_event_prev && !i_event_next && !i_event_erase && q.ecur != 7'h00)
            |=> q.ecur == $past(q.ecur) - 7'h1)
        else $error("event cursor did not step back");
    a_trip_browse: assert property (
        (i_trip_next && !i_trip_erase && !i_val_next && !i_val_prev && q.tcur + 4'h1 < q.tcnt)
            |=> q.tcur == $past(q.tcur) + 4'h1 && q.vcur == 3'h0)
        else $error("trip cursor did not step forward");
    a_trip_back: assert property (
        (i_trip_prev && !i_trip_next && !i_trip_erase && q.tcur != 4'h0)
            |=> q.tcur == $past(q.tcur) - 4'h1)
        else $error("trip cursor did not step back");
    a_val_step: assert property (
        (i_val_next && !i_trip_next && !i_trip_prev && !i_trip_erase)
            |=> o_trip_value_idx == $past(q.vcur) + 3'h1)
        else $error("value cursor did not advance");
    a_trip_meas: assert property (
        (tr_log && !i_trip_erase) |=> q.trip[$past(q.twp)].meas == $past(i_meas)
            && q.trip[$past(q.twp)].fid == $past(pick))
        else $error("trip entry lost its function or measurements");
    a_evt_stamp: assert property (
        (ev_log && !i_event_erase) |=> q.evt[$past(q.ewp)].ts == $past(i_stamp))
        else $error("event stamp not latched at detection");
    a_evt_full: assert property (
        (ev_log && !i_event_erase && q.ecnt == 7'(`EVT_DEPTH))
            |=> q.ecnt == 7'(`EVT_DEPTH))
        else $error("full event log changed its count");
    a_evt_wrap: assert property (
        (ev_log && !i_event_erase && q.ewp == 7'(`EVT_DEPTH - 1)) |=> q.ewp == 7'h00)
        else $error("event write slot did not wrap");
    a_start_fall: assert property (
        (found && !rise && pick >= 6'(`FID_START) && pick < 6'(`FID_TRIP) && !i_event_erase)
            |=> q.ecnt == $past(q.ecnt))
        else $error("falling start was logged");
    a_trip_fall: assert property (
        (found && !rise && pick >= 6'(`FID_TRIP) && !i_event_erase && !i_trip_erase)
            |=> q.tcnt == $past(q.tcnt) && q.evt[$past(q.ewp)].rise == 1'b0)
        else $error("trip reset not logged as a fall");
    a_io_change: assert property (
        (found && pick < 6'(`FID_START) && !i_event_erase && q.ecnt != 7'(`EVT_DEPTH))
            |=> q.ecnt == $past(q.ecnt) + 7'h1)
        else $error("input change not logged");
    a_total_cl: assert property (
        i_cnt_view == 5'(`IDX_TOT_CL)
            |=> o_cnt_value == {1'b0, q.cnt[`IDX_MANUAL_BREAKER_CLOSINGS]} + {1'b0, q.cnt[`IDX_AUTOMATIC_BREAKER_CLOSINGS]})
        else $error("closing total differs from sum");
    a_energy_hold: assert property (
        (!i_energy_tick[1] && !i_energy_erase) |=> o_energy[1] == $past(o_energy[1]))
        else $error("idle energy accumulator moved");
    a_energy_step: assert property (
        (i_energy_tick[2] && !i_energy_erase && q.en[2] != `ENERGY_MAX)
            |=> o_energy[2] == $past(q.en[2]) + 24'h1)
        else $error("energy accumulator missed a tick");

    c_trip_full: cover property (tr_log && q.tcnt == 4'(`TRIP_DEPTH));
    c_evt_wrap: cover property (ev_log && q.ewp == 7'(`EVT_DEPTH - 1));
    c_trip_reset: cover property (found && !rise && pick >= 6'(`FID_TRIP));
    c_browse_back: cover property (i_trip_prev && q.tcur != 4'h0);
    c_evt_full: cover property (ev_log && q.ecnt == 7'(`EVT_DEPTH));

endmodule
`default_nettype wire

/* File: dv/panel_operator.sv */
/*
 Front panel operator of the recorder: erase keys and browse keys.
 Assumes the bench calls press from its main sequence, one key at a time.
*/
`timescale 1ns/1ps
`default_nettype none

module panel_operator (
    input  wire logic       i_clk,
    output logic [8:0]      o_key
);
    // Key map: 0..2 energy/trip/event erase, 3..8 browse increase/decrease
    logic pass_ok;

    // Keys idle at power-up
    initial begin
        o_key   = 9'h000;
        pass_ok = 1'b0;
    end

    // One key held for one clock, launched and dropped at falling edges
    task automatic press(input int k, input logic pw);
        @(negedge i_clk);
        pass_ok = pw;
        if (k > 2 || pass_ok) begin
            o_key[k] = 1'b1;
        end
        @(negedge i_clk);
        o_key = 9'h000;
    endtask
endmodule

`default_nettype wire

/* File: dv/relay_event_trip_recorder_bench.sv */
/*
 Self-checking bench of the relay recorder: energy, trips, events, counters.
 Assumes the recorder package, its defines and the panel operator model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "recorder_defines.svh"

module relay_event_trip_recorder_bench;
    import recorder_pkg::*;
    logic             i_clk, i_rst_b, cnt_load, cmd_done, no_trips, no_events, ev_rise;
    stamp_t           stamp, trip_stamp, ev_stamp;
    logic [3:0]       etick, trip_count;
    logic [8:0]       key;
    logic [7:0]       dio;
    logic [15:0]      start, trip;
    meas_t [7:0]      meas;
    logic [28:0]      op_tick;
    logic [4:0]       cnt_sel, cnt_view;
    count_t           cnt_value;
    energy_t [3:0]    energy;
    fid_t             trip_fid, ev_fid;
    meas_t            trip_val;
    logic [2:0]       val_idx;
    logic [6:0]       ev_count;
    logic [16:0]      cnt_out;
    int               errors, tests_run;

    panel_operator op (.i_clk(i_clk), .o_key(key));

    relay_event_trip_recorder dut (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_stamp(stamp), .i_energy_tick(etick),
        .i_energy_erase(key[0]), .i_trip_erase(key[1]), .i_event_erase(key[2]),
        .o_cmd_done(cmd_done), .o_energy(energy), .i_dio(dio), .i_start(start),
        .i_trip(trip), .i_meas(meas), .i_trip_next(key[3]), .i_trip_prev(key[4]),
        .i_val_next(key[5]), .i_val_prev(key[6]), .o_no_trips(no_trips),
        .o_trip_count(trip_count), .o_trip_fid(trip_fid), .o_trip_stamp(trip_stamp),
        .o_trip_value(trip_val), .o_trip_value_idx(val_idx), .i_event_next(key[7]),
        .i_event_prev(key[8]), .o_no_events(no_events), .o_event_count(ev_count),
        .o_event_fid(ev_fid), .o_event_rise(ev_rise), .o_event_stamp(ev_stamp),
        .i_op_tick(op_tick), .i_cnt_load(cnt_load), .i_cnt_sel(cnt_sel),
        .i_cnt_value(cnt_value), .i_cnt_view(cnt_view), .o_cnt_value(cnt_out));

    // 40 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    // Compare and count
    task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Bounded wait for the completion pulse
    task automatic see_done;
        for (int i = 0; i < 4 && cmd_done !== 1'b1; i++) cyc(1);
        chk("cmd_done", cmd_done, 1'b1);
        if (cmd_done !== 1'b1) summarize;
        cyc(2);
    endtask

    // Ticks per accumulator, refused and accepted erase
    task automatic t_energy;
        chk("no_trips", no_trips, 1'b1);
        chk("no_events", no_events, 1'b1);
        etick = 4'hf;
        cyc(3);
        etick = 4'h5;
        cyc(1);
        etick = 4'h0;
        cyc(2);
        for (int i = 0; i < 4; i++) chk("energy", energy[i], (i % 2) ? 3 : 4);
        op.press(0, 1'b0);
        cyc(2);
        chk("energy kept", energy[0], 24'h000004);
        op.press(0, 1'b1);
        see_done();
        for (int i = 0; i < 4; i++) chk("energy erased", energy[i], 24'h000000);
        $display("energy test finished");
    endtask

    // One trip: entries, stamps, measurement browse, fall and start events
    task automatic t_trip;
        stamp = 43'h1a2b3c4d5e6;
        for (int i = 0; i < 8; i++) meas[i] = 16'h0100 + 16'(i);
        trip[0] = 1'b1;
        cyc(3);
        meas = '0;
        chk("trip_count", trip_count, 4'h1);
        chk("trip_fid", trip_fid, 6'h18);
        chk("trip_stamp", trip_stamp, 43'h1a2b3c4d5e6);
        chk("ev_fid", ev_fid, 6'h18);
        chk("ev_rise", ev_rise, 1'b1);
        op.press(5, 1'b0);
        op.press(5, 1'b0);
        cyc(2);
        chk("trip_val", trip_val, 16'h0102);
        repeat (3) op.press(6, 1'b0);
        cyc(2);
        chk("val_idx", val_idx, 3'h7);
        chk("trip_val", trip_val, 16'h0107);
        stamp = 43'h00f0e0d0c0b;
        trip[0] = 1'b0;
        cyc(3);
        op.press(7, 1'b0);
        cyc(2);
        chk("ev_rise fall", ev_rise, 1'b0);
        chk("ev_stamp", ev_stamp, 43'h00f0e0d0c0b);
        start[1] = 1'b1;
        cyc(3);
        start[1] = 1'b0;
        cyc(3);
        chk("ev_count", ev_count, 7'h03);
        op.press(7, 1'b0);
        op.press(7, 1'b0);
        cyc(2);
        chk("ev_fid start", ev_fid, 6'h09);
        $display("trip test finished");
    endtask

    // Trip overflow, browse, erase
    task automatic t_fifo;
        for (int p = 1; p < 12; p++) begin
            trip[p] = 1'b1;
            cyc(2);
            trip[p] = 1'b0;
            cyc(2);
        end
        cyc(2);
        chk("trip_count full", trip_count, 4'ha);
        chk("oldest trip", trip_fid, 6'h1a);
        op.press(3, 1'b0);
        cyc(2);
        chk("next trip", trip_fid, 6'h1b);
        op.press(4, 1'b0);
        op.press(4, 1'b0);
        cyc(2);
        chk("prev trip", trip_fid, 6'h1a);
        op.press(1, 1'b1);
        see_done();
        chk("no_trips", no_trips, 1'b1);
        chk("trip_count", trip_count, 4'h0);
        $display("fifo test finished");
    endtask

    // Event log overflow from input changes, then erase
    task automatic t_events;
        repeat (80) begin
            dio[0] = ~dio[0];
            cyc(4);
        end
        chk("ev_count full", ev_count, 7'h64);
        chk("ev_fid shifted", ev_fid, 6'h1b);
        op.press(8, 1'b0);
        op.press(8, 1'b0);
        cyc(2);
        chk("ev_fid oldest", ev_fid, 6'h1a);
        op.press(2, 1'b1);
        see_done();
        chk("no_events", no_events, 1'b1);
        chk("ev_count", ev_count, 7'h00);
        $display("event test finished");
    endtask

    task automatic load(input logic [4:0] sel, input count_t val);
        cnt_sel = sel;
        cnt_value = val;
        cnt_load = 1'b1;
        cyc(1);
        cnt_load = 1'b0;
        cyc(2);
    endtask

    // Operation counters, totals, load and refused load
    task automatic t_count;
        op_tick[27] = 1'b1;
        cyc(2);
        op_tick[27] = 1'b0;
        op_tick[25] = 1'b1;
        cyc(1);
        op_tick[25] = 1'b0;
        cnt_view = 5'h1d;
        cyc(2);
        chk("total open", cnt_out, 17'h00003);
        cnt_view = 5'h1e;
        cyc(2);
        chk("total close", cnt_out, 17'h00000);
        load(5'h03, 16'h1233);
        op_tick[3] = 1'b1;
        cyc(2);
        op_tick[3] = 1'b0;
        cnt_view = 5'h03;
        cyc(2);
        chk("loaded count", cnt_out, 17'h01235);
        load(5'h1b, 16'h0000);
        load(5'h1d, 16'h0005);
        cnt_view = 5'h1d;
        cyc(2);
        chk("total after reset", cnt_out, 17'h00001);
        $display("counter test finished");
    endtask

    // Reset, then the scenarios in turn
    initial begin
        errors = 0;
        tests_run = 0;
        i_rst_b = 1'b0;
        stamp = '0;
        etick = 4'h0;
        dio = 8'h00;
        start = 16'h0000;
        trip = 16'h0000;
        meas = '0;
        op_tick = '0;
        cnt_load = 1'b0;
        cnt_sel = 5'h00;
        cnt_value = 16'h0000;
        cnt_view = 5'h00;
        cyc(6);
        i_rst_b = 1'b1;
        cyc(2);
        t_energy();
        t_trip();
        t_fifo();
        t_events();
        t_count();
        summarize();
    end
endmodule

`default_nettype wire
